// ===== irq_route_pkg.sv
/*
  Shared constants for the multi-I/O interrupt router: register offsets,
  field positions, reset values, serial port address codes and timing.
  Assumes a single 100 MHz system clock.
*/
package irq_route_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [3:0] OFF_CFG         = 4'h0;
  localparam logic [3:0] OFF_UART0_IER   = 4'h1;
  localparam logic [3:0] OFF_UART1_IER   = 4'h2;
  localparam logic [3:0] OFF_FDD_DOR     = 4'h3;
  localparam logic [3:0] OFF_LPT_CTRL    = 4'h4;
  localparam logic [3:0] OFF_STATUS      = 4'h5;
  localparam logic [3:0] OFF_CLEAR       = 4'h6;
  localparam logic [3:0] OFF_ENABLE      = 4'h7;
  localparam logic [3:0] OFF_STRAPS      = 4'h8;
  localparam logic [3:0] OFF_LINES       = 4'h9;

  localparam int unsigned CFG_UART0_LSB  = 0;
  localparam int unsigned CFG_UART1_LSB  = 2;
  localparam int unsigned FDD_DOR_IRQ_EN = 3;
  localparam int unsigned LPT_CTRL_IRQ_EN = 4;

  localparam logic [1:0] COM1 = 2'h0;
  localparam logic [1:0] COM2 = 2'h1;
  localparam logic [1:0] COM3 = 2'h2;
  localparam logic [1:0] COM4 = 2'h3;

  localparam logic [7:0] CFG_RST = 8'h04;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] DOR_RST = 8'h00;
  localparam logic [7:0] LPT_RST = 8'h00;

  localparam int unsigned N_EVT = 4;
  localparam int unsigned EVT_UART0 = 0;
  localparam int unsigned EVT_UART1 = 1;
  localparam int unsigned EVT_FDD   = 2;
  localparam int unsigned EVT_LPT   = 3;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RST_MIN_NS    = 500;
  localparam int unsigned RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== irq_route.sv
/*
  Interrupt router for the serial, floppy and printer port blocks of a
  multi-function I/O device, with its enable registers and event status.
  Assumes the source request levels come from logic on i_sys_clk, while
  the host reset pin and board jumper lines arrive asynchronously.
*/
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps

// How it works
// - Motherboard: COM1/COM3 port drives first line.
// - Motherboard: COM2/COM4 port drives second line.
// - Serial requests gated by their enable register.
// - Serial output drops when serviced, disabled, reset.
// - Adapter: primary serial on its own output.
// - Adapter: secondary serial on its own output.
// - Floppy output needs floppy register bit 3.
// - Printer output needs printer control bit 4.
// - Host reset keeps configuration registers intact.
// - Adapter: jumpers latched on reset falling edge.
// - Adapter: printer strap sampled during reset.
module irq_route #(
  parameter bit ADAPTER = 1'b0
) (
  input  wire logic                               i_sys_clk,
  input  wire logic                               i_sys_rst,
  input  wire logic                               i_host_rst,
  input  wire logic [irq_route_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [irq_route_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                               i_wr,
  input  wire logic                               i_rd,
  output logic      [irq_route_pkg::DATA_W-1:0]   o_rdata,
  input  wire logic [irq_route_pkg::DATA_W-1:0]   i_uart0_cause,
  input  wire logic [irq_route_pkg::DATA_W-1:0]   i_uart1_cause,
  input  wire logic                               i_floppy_req,
  input  wire logic                               i_printer_req,
  input  wire logic [3:0]                         i_jumpers,
  input  wire logic                               i_printer_port_cfg_strap0,
  output logic                                    o_irq_com13,
  output logic                                    o_irq_com24,
  output logic                                    o_primary_uart_irq_out,
  output logic                                    o_secondary_uart_irq_out,
  output logic                                    o_floppy_irq_out,
  output logic                                    o_printer_port_irq_out,
  output logic      [3:0]                         o_jumper_latch,
  output logic                                    o_printer_port_addr_sel,
  output logic                                    o_irq
);

  localparam int unsigned DW = irq_route_pkg::DATA_W;
  localparam int unsigned NE = irq_route_pkg::N_EVT;

  // Asynchronous pins pass two flip-flops before any use.
  logic       host_rst_s1_q;
  logic       host_rst_s2_q;
  logic       host_rst_d1_q;
  logic [3:0] jmp_s1_q;
  logic [3:0] jmp_s2_q;
  logic       strap_s1_q;
  logic       strap_s2_q;

  // Configuration registers, cleared only by the system reset.
  logic [DW-1:0] config_reg_one_q;

  // Device registers, also cleared by the host reset pin.
  logic [DW-1:0] uart0_irq_enable_reg_q;
  logic [DW-1:0] uart1_irq_enable_reg_q;
  logic [DW-1:0] floppy_drive_output_reg_q;
  logic [DW-1:0] printer_ctrl_q;
  logic [NE-1:0] evt_status_q;
  logic [NE-1:0] evt_enable_q;
  logic [NE-1:0] line_prev_q;

  logic [3:0] jumper_latch_q;
  logic       strap_latch_q;
  logic [DW-1:0] rdata_q;

  logic p_com13_q;
  logic p_com24_q;
  logic p_uart0_q;
  logic p_uart1_q;
  logic p_fdd_q;
  logic p_lpt_q;

  function automatic logic is_com13(input logic [1:0] code);
    is_com13 = (code == irq_route_pkg::COM1) || (code == irq_route_pkg::COM3);
  endfunction

  function automatic logic is_com24(input logic [1:0] code);
    is_com24 = (code == irq_route_pkg::COM2) || (code == irq_route_pkg::COM4);
  endfunction

  wire logic any_rst   = i_sys_rst | host_rst_s2_q;
  wire logic rst_fall  = host_rst_d1_q & ~host_rst_s2_q;

  wire logic [1:0] uart0_code = config_reg_one_q[irq_route_pkg::CFG_UART0_LSB +: 2];
  wire logic [1:0] uart1_code = config_reg_one_q[irq_route_pkg::CFG_UART1_LSB +: 2];

  // A cause stays pending until the serial block clears it on service.
  wire logic uart0_act = |(i_uart0_cause & uart0_irq_enable_reg_q);
  wire logic uart1_act = |(i_uart1_cause & uart1_irq_enable_reg_q);

  wire logic com13_d = (uart0_act & is_com13(uart0_code))
                     | (uart1_act & is_com13(uart1_code));
  wire logic com24_d = (uart0_act & is_com24(uart0_code))
                     | (uart1_act & is_com24(uart1_code));

  wire logic fdd_d = i_floppy_req & floppy_drive_output_reg_q[irq_route_pkg::FDD_DOR_IRQ_EN];
  wire logic lpt_d = i_printer_req & printer_ctrl_q[irq_route_pkg::LPT_CTRL_IRQ_EN];

  wire logic [NE-1:0] line_now = {lpt_d, fdd_d, uart1_act, uart0_act};
  wire logic [NE-1:0] evt_rise = line_now & ~line_prev_q;

  wire logic wr_cfg   = i_wr & (i_addr == irq_route_pkg::OFF_CFG);
  wire logic wr_ier0  = i_wr & (i_addr == irq_route_pkg::OFF_UART0_IER);
  wire logic wr_ier1  = i_wr & (i_addr == irq_route_pkg::OFF_UART1_IER);
  wire logic wr_dor   = i_wr & (i_addr == irq_route_pkg::OFF_FDD_DOR);
  wire logic wr_lpt   = i_wr & (i_addr == irq_route_pkg::OFF_LPT_CTRL);
  wire logic wr_clr   = i_wr & (i_addr == irq_route_pkg::OFF_CLEAR);
  wire logic wr_en    = i_wr & (i_addr == irq_route_pkg::OFF_ENABLE);

  wire logic [NE-1:0] clr_mask = wr_clr ? i_wdata[NE-1:0] : '0;

  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (i_addr)
      irq_route_pkg::OFF_CFG:       rd_mux = config_reg_one_q;
      irq_route_pkg::OFF_UART0_IER: rd_mux = uart0_irq_enable_reg_q;
      irq_route_pkg::OFF_UART1_IER: rd_mux = uart1_irq_enable_reg_q;
      irq_route_pkg::OFF_FDD_DOR:   rd_mux = floppy_drive_output_reg_q;
      irq_route_pkg::OFF_LPT_CTRL:  rd_mux = printer_ctrl_q;
      irq_route_pkg::OFF_STATUS:    rd_mux[NE-1:0] = evt_status_q;
      irq_route_pkg::OFF_ENABLE:    rd_mux[NE-1:0] = evt_enable_q;
      irq_route_pkg::OFF_STRAPS:    rd_mux[4:0] = {strap_latch_q, jumper_latch_q};
      irq_route_pkg::OFF_LINES:     rd_mux[5:0] = {p_lpt_q, p_fdd_q, p_com24_q, p_com13_q, p_uart1_q, p_uart0_q};
      default:                      rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    host_rst_s1_q <= i_host_rst;
    host_rst_s2_q <= host_rst_s1_q;
    jmp_s1_q      <= i_jumpers;
    jmp_s2_q      <= jmp_s1_q;
    strap_s1_q    <= i_printer_port_cfg_strap0;
    strap_s2_q    <= strap_s1_q;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      host_rst_d1_q <= 1'b0;
    end else begin
      host_rst_d1_q <= host_rst_s2_q;
    end
  end

  // The host reset pin never touches this register.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      config_reg_one_q <= irq_route_pkg::CFG_RST;
    end else if (wr_cfg) begin
      config_reg_one_q <= i_wdata;
    end
  end

  // Host reset holds these at reset value; a host reset shorter than the
  // minimum width may be missed by the synchroniser.
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      uart0_irq_enable_reg_q    <= irq_route_pkg::IER_RST;
      uart1_irq_enable_reg_q    <= irq_route_pkg::IER_RST;
      floppy_drive_output_reg_q <= irq_route_pkg::DOR_RST;
      printer_ctrl_q            <= irq_route_pkg::LPT_RST;
    end else begin
      if (wr_ier0) begin
        uart0_irq_enable_reg_q <= i_wdata;
      end
      if (wr_ier1) begin
        uart1_irq_enable_reg_q <= i_wdata;
      end
      if (wr_dor) begin
        floppy_drive_output_reg_q <= i_wdata;
      end
      if (wr_lpt) begin
        printer_ctrl_q <= i_wdata;
      end
    end
  end

  // Status bits are sticky; a new event wins over a clear in the same cycle.
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      evt_status_q <= '0;
      evt_enable_q <= '0;
      line_prev_q  <= '0;
    end else begin
      evt_status_q <= (evt_status_q & ~clr_mask) | evt_rise;
      line_prev_q  <= line_now;
      if (wr_en) begin
        evt_enable_q <= i_wdata[NE-1:0];
      end
    end
  end

  // On the adapter variant, jumpers are captured on the falling edge of the host reset, the strap
  // follows its pin for as long as the reset stays active.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      jumper_latch_q <= '0;
      strap_latch_q  <= 1'b0;
    end else begin
      if (ADAPTER && rst_fall) begin
        jumper_latch_q <= jmp_s2_q;
      end
      if (ADAPTER && host_rst_s2_q) begin
        strap_latch_q <= strap_s2_q;
      end
    end
  end

  // Pin outputs; each variant drives only its own pin set.
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      p_com13_q <= 1'b0;
      p_com24_q <= 1'b0;
      p_uart0_q <= 1'b0;
      p_uart1_q <= 1'b0;
      p_fdd_q   <= 1'b0;
      p_lpt_q   <= 1'b0;
    end else begin
      p_com13_q <= !ADAPTER && com13_d;
      p_com24_q <= !ADAPTER && com24_d;
      p_uart0_q <= ADAPTER && uart0_act;
      p_uart1_q <= ADAPTER && uart1_act;
      p_fdd_q   <= fdd_d;
      p_lpt_q   <= lpt_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rdata_q <= '0;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_irq_com13              = p_com13_q;
  assign o_irq_com24              = p_com24_q;
  assign o_primary_uart_irq_out   = p_uart0_q;
  assign o_secondary_uart_irq_out = p_uart1_q;
  assign o_floppy_irq_out         = p_fdd_q;
  assign o_printer_port_irq_out   = p_lpt_q;
  assign o_jumper_latch           = jumper_latch_q;
  assign o_printer_port_addr_sel  = strap_latch_q;
  assign o_rdata                  = rdata_q;
  assign o_irq                    = |(evt_status_q & evt_enable_q);

endmodule

// ===== irq_route_chk.sv
/*
  Port checker for the interrupt router, bound into every instance.
  Assumes the single i_sys_clk domain and the synchronous i_sys_rst.
*/
`timescale 1ns/1ps
module irq_route_chk #(
  parameter bit ADAPTER = 1'b0
) (
  input wire logic                             i_sys_clk,
  input wire logic                             i_sys_rst,
  input wire logic                             i_host_rst,
  input wire logic                             i_rd,
  input wire logic [irq_route_pkg::DATA_W-1:0] o_rdata,
  input wire logic [irq_route_pkg::DATA_W-1:0] i_uart0_cause,
  input wire logic [irq_route_pkg::DATA_W-1:0] i_uart1_cause,
  input wire logic                             i_floppy_req,
  input wire logic                             i_printer_req,
  input wire logic                             o_irq_com13,
  input wire logic                             o_irq_com24,
  input wire logic                             o_primary_uart_irq_out,
  input wire logic                             o_secondary_uart_irq_out,
  input wire logic                             o_floppy_irq_out,
  input wire logic                             o_printer_port_irq_out
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  AST_FLOPPY_GATE: assert property (o_floppy_irq_out |-> $past(i_floppy_req))
    else $error("floppy output high without a request");
  AST_PRINTER_GATE: assert property (o_printer_port_irq_out |-> $past(i_printer_req))
    else $error("printer output high without a request");
  AST_SERIAL_DROP: assert property (i_uart0_cause == 8'h00 && i_uart1_cause == 8'h00 |=> !o_irq_com13 && !o_irq_com24)
    else $error("serial line stayed high after service");
  AST_SYS_RST_QUIET: assert property (disable iff (1'b0) i_sys_rst |=>
    !o_irq_com13 && !o_irq_com24 && !o_floppy_irq_out && !o_printer_port_irq_out)
    else $error("interrupt output high during reset");
  AST_HOST_RST_QUIET: assert property (i_host_rst [*4] |=> !o_irq_com13 && !o_irq_com24 &&
    !o_floppy_irq_out && !o_printer_port_irq_out && !o_primary_uart_irq_out && !o_secondary_uart_irq_out)
    else $error("interrupt output high during host reset");
  AST_RDATA_ONE_CYCLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_BOARD_SPLIT: assert property (!ADAPTER |-> !o_primary_uart_irq_out && !o_secondary_uart_irq_out)
    else $error("adapter output active on motherboard variant");
  AST_ADAPTER_SPLIT: assert property (ADAPTER |-> !o_irq_com13 && !o_irq_com24)
    else $error("shared line active on adapter variant");
endmodule

bind irq_route irq_route_chk #(.ADAPTER(ADAPTER)) irq_route_chk_inst (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_host_rst(i_host_rst), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_uart0_cause(i_uart0_cause), .i_uart1_cause(i_uart1_cause),
  .i_floppy_req(i_floppy_req), .i_printer_req(i_printer_req), .o_irq_com13(o_irq_com13),
  .o_irq_com24(o_irq_com24), .o_primary_uart_irq_out(o_primary_uart_irq_out),
  .o_secondary_uart_irq_out(o_secondary_uart_irq_out), .o_floppy_irq_out(o_floppy_irq_out),
  .o_printer_port_irq_out(o_printer_port_irq_out));

// ===== host_rst_src.sv
/*
  Host reset source: one request gives a reset pulse of HOLD_CYC cycles.
  Assumes the 100 MHz i_sys_clk.
*/
`timescale 1ns/1ps
module host_rst_src #(
  parameter int unsigned HOLD_CYC = irq_route_pkg::RST_MIN_CYC
) (
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_pulse,
  output logic      o_host_rst
);
  int unsigned cnt_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cnt_q <= 0;
    end else if (i_pulse) begin
      cnt_q <= HOLD_CYC;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign o_host_rst = (cnt_q != 0);
endmodule

// ===== multi_io_interrupt_routing_tb_top.sv
/*
  Self-checking testbench for the interrupt router, motherboard and adapter variants.
  Assumes host_rst_src drives the host reset pin.
*/
`timescale 1ns/1ps
module multi_io_interrupt_routing_tb_top;
  localparam int unsigned HOLD = irq_route_pkg::RST_MIN_CYC + 4;
  logic       i_sys_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] i_uart0_cause = 8'h00;
  logic [7:0] i_uart1_cause = 8'h00;
  logic       i_floppy_req = 1'b0;
  logic       i_printer_req = 1'b0;
  logic       host_go = 1'b0;
  wire logic  i_host_rst;
  logic [7:0] o_rdata;
  logic       o_irq_com13, o_irq_com24, o_primary, o_secondary, o_floppy, o_printer, o_irq;
  logic [7:0] v;
  logic [3:0] jumpers = 4'h0;
  logic       strap = 1'b0;
  logic       o_primary_a, o_secondary_a, o_addr_sel_a;
  logic [3:0] o_jumper_latch_a;
  int         failures = 0;
  int         compares = 0;

  irq_route #(.ADAPTER(1'b0)) irq_route_inst (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_host_rst(i_host_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_uart0_cause(i_uart0_cause),
    .i_uart1_cause(i_uart1_cause), .i_floppy_req(i_floppy_req), .i_printer_req(i_printer_req),
    .i_jumpers(4'h0), .i_printer_port_cfg_strap0(1'b0), .o_irq_com13(o_irq_com13),
    .o_irq_com24(o_irq_com24), .o_primary_uart_irq_out(o_primary), .o_secondary_uart_irq_out(o_secondary),
    .o_floppy_irq_out(o_floppy), .o_printer_port_irq_out(o_printer), .o_jumper_latch(),
    .o_printer_port_addr_sel(), .o_irq(o_irq));
  irq_route #(.ADAPTER(1'b1)) irq_route_adapter_inst (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_host_rst(i_host_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(), .i_uart0_cause(i_uart0_cause),
    .i_uart1_cause(i_uart1_cause), .i_floppy_req(i_floppy_req), .i_printer_req(i_printer_req),
    .i_jumpers(jumpers), .i_printer_port_cfg_strap0(strap), .o_irq_com13(),
    .o_irq_com24(), .o_primary_uart_irq_out(o_primary_a), .o_secondary_uart_irq_out(o_secondary_a),
    .o_floppy_irq_out(), .o_printer_port_irq_out(), .o_jumper_latch(o_jumper_latch_a),
    .o_printer_port_addr_sel(o_addr_sel_a), .o_irq());
  host_rst_src #(.HOLD_CYC(HOLD)) host_rst_src_inst (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_pulse(host_go), .o_host_rst(i_host_rst));

  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task automatic settle;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("Counts: compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic t_regs;
    rd(irq_route_pkg::OFF_CFG);
    check(v, irq_route_pkg::CFG_RST);
    rd(4'hF);
    check(v, 8'h00);
    wr(irq_route_pkg::OFF_STATUS, 8'hFF);
    rd(irq_route_pkg::OFF_STATUS);
    check(v, 8'h00);
  endtask
  task automatic t_route;
    wr(irq_route_pkg::OFF_UART0_IER, 8'h01);
    i_uart0_cause <= 8'h01;
    for (int c = 0; c < 4; c++) begin
      wr(irq_route_pkg::OFF_CFG, {6'h00, 2'(c)});
      settle();
      check({6'h00, o_irq_com24, o_irq_com13}, (2'(c) == irq_route_pkg::COM1 || 2'(c) == irq_route_pkg::COM3)
        ? 8'h01 : 8'h02);
    end
    check({6'h00, o_secondary, o_primary}, 8'h00);
    check({6'h00, o_secondary_a, o_primary_a}, 8'h01);
    i_uart0_cause <= 8'h02;
    settle();
    check({6'h00, o_irq_com24, o_irq_com13}, 8'h00);
    check({6'h00, o_secondary_a, o_primary_a}, 8'h00);
  endtask
  task automatic t_shared;
    wr(irq_route_pkg::OFF_CFG, 8'h0D);
    wr(irq_route_pkg::OFF_UART1_IER, 8'h01);
    i_uart0_cause <= 8'h00;
    i_uart1_cause <= 8'h01;
    settle();
    check({6'h00, o_irq_com24, o_irq_com13}, 8'h02);
    check({6'h00, o_secondary_a, o_primary_a}, 8'h02);
    i_uart0_cause <= 8'h01;
    i_uart1_cause <= 8'h00;
    settle();
    check({6'h00, o_irq_com24, o_irq_com13}, 8'h02);
    check({6'h00, o_secondary_a, o_primary_a}, 8'h01);
  endtask
  task automatic t_irq;
    i_floppy_req <= 1'b1;
    i_printer_req <= 1'b1;
    settle();
    check({6'h00, o_printer, o_floppy}, 8'h00);
    wr(irq_route_pkg::OFF_FDD_DOR, 8'h08);
    wr(irq_route_pkg::OFF_LPT_CTRL, 8'h10);
    wr(irq_route_pkg::OFF_ENABLE, 8'h04);
    settle();
    check({6'h00, o_printer, o_floppy}, 8'h03);
    check({7'h00, o_irq}, 8'h01);
    wr(irq_route_pkg::OFF_CLEAR, 8'h0F);
    rd(irq_route_pkg::OFF_STATUS);
    check(v, 8'h00);
    check({7'h00, o_irq}, 8'h00);
  endtask
  task automatic t_host;
    @(posedge i_sys_clk);
    host_go <= 1'b1;
    jumpers <= 4'h5;
    strap <= 1'b1;
    @(posedge i_sys_clk);
    host_go <= 1'b0;
    settle();
    settle();
    check({6'h00, o_printer, o_floppy}, 8'h00);
    check({6'h00, o_secondary_a, o_primary_a}, 8'h00);
    repeat (HOLD + 4) @(posedge i_sys_clk);
    rd(irq_route_pkg::OFF_CFG);
    check(v, 8'h0D);
    rd(irq_route_pkg::OFF_FDD_DOR);
    check(v, irq_route_pkg::DOR_RST);
    settle();
    check({4'h0, o_printer, o_floppy, o_irq_com24, o_irq_com13}, 8'h00);
    check({4'h0, o_jumper_latch_a}, 8'h05);
    check({7'h00, o_addr_sel_a}, 8'h01);
    jumpers <= 4'hA;
    strap <= 1'b0;
    settle();
    settle();
    check({4'h0, o_jumper_latch_a}, 8'h05);
    check({7'h00, o_addr_sel_a}, 8'h01);
  endtask

  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_route();
    t_shared();
    t_irq();
    t_host();
    finish_test();
  end
  initial begin
    #50000;
    failures++;
    finish_test();
  end
endmodule
